//--- sgdp_pkg.sv
package sgdp_pkg;
  // register offsets (byte addresses in the register window)
  localparam logic [7:0] CUR_DESC_OFS = 8'h08;
  localparam logic [7:0] TAIL_DESC_OFS = 8'h10;
  localparam logic [7:0] SRC_ADDR_OFS = 8'h18;
  // pointer field layout: low bits forced to zero
  localparam int PTR_LSB = 6;
  localparam logic [31:0] PTR_MASK = 32'hffffffc0;
  // descriptor stride in bytes
  localparam logic [31:0] DESC_STRIDE = 32'h00000040;
  // reset values
  localparam logic [31:0] CUR_DESC_RST = 32'h00000000;
  localparam logic [31:0] TAIL_DESC_RST = 32'h00000000;
  localparam logic [31:0] SRC_ADDR_RST = 32'h00000000;
  // width of the register window address
  localparam int REG_AW = 8;
endpackage : sgdp_pkg

//--- sgdp_ptr_reg.sv
`timescale 1ns/100ps
// one pointer/address register with optional low-bit masking
module sgdp_ptr_reg
  import sgdp_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h00000000,
  parameter logic [31:0] KEEP_MASK = 32'hffffffff
) (
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic swWr,
  input wire logic [31:0] swData,
  input wire logic hwWr,
  input wire logic [31:0] hwData,
  output logic [31:0] value
);
  logic [31:0] valQ;
  logic [31:0] valD;
  // hardware update wins over software write in the same cycle
  assign valD = hwWr ? (hwData & KEEP_MASK) : (swWr ? (swData & KEEP_MASK) : valQ);
  // storage
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      valQ <= RST_VAL;
    end else begin
      valQ <= valD;
    end
  end
  assign value = valQ;
endmodule : sgdp_ptr_reg

//--- sgdp_desc_ptrs.sv
`timescale 1ns/100ps
module sgdp_desc_ptrs
  import sgdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic regWr,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  input wire logic scatterGatherSelect,
  input wire logic fetchReady,
  input wire logic descDone,
  input wire logic [31:0] nextDescPtr,
  input wire logic errValid,
  input wire logic [31:0] errDescPtr,
  input wire logic simpleStart,
  output logic fetchReq,
  output logic [31:0] fetchAddr,
  output logic simpleReq,
  output logic [31:0] simpleSrcAddr,
  output logic engineIdle,
  output logic enginePaused
);
  // reset synchroniser
  logic rstMetaQ;
  logic rstSyncQ;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMetaQ <= 1'b0;
      rstSyncQ <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstSyncQ <= rstMetaQ;
    end
  end

  // engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_PAUSE = 4'b1000
  } sgdp_state_e;
  sgdp_state_e stateQ;
  sgdp_state_e stateD;

  // address decode
  wire selCur = regAddr == CUR_DESC_OFS;
  wire selTail = regAddr == TAIL_DESC_OFS;
  wire selSrc = regAddr == SRC_ADDR_OFS;
  wire wrCur = regWr && selCur;
  wire wrTail = regWr && selTail;
  wire wrSrc = regWr && selSrc;
  wire chainMode = scatterGatherSelect;

  logic [31:0] curPtr;
  logic [31:0] tailPtr;
  logic [31:0] srcAddr;
  logic hwCurWr;
  logic [31:0] hwCurData;

  sgdp_ptr_reg #(.RST_VAL(CUR_DESC_RST), .KEEP_MASK(PTR_MASK)) uCur (
    .clk(ref_clk),
    .rstSyncN(rstSyncQ),
    .swWr(wrCur),
    .swData(regWdata),
    .hwWr(hwCurWr),
    .hwData(hwCurData),
    .value(curPtr)
  );
  sgdp_ptr_reg #(.RST_VAL(TAIL_DESC_RST), .KEEP_MASK(PTR_MASK)) uTail (
    .clk(ref_clk),
    .rstSyncN(rstSyncQ),
    .swWr(wrTail),
    .swData(regWdata),
    .hwWr(1'b0),
    .hwData(32'h00000000),
    .value(tailPtr)
  );
  sgdp_ptr_reg #(.RST_VAL(SRC_ADDR_RST), .KEEP_MASK(32'hffffffff)) uSrc (
    .clk(ref_clk),
    .rstSyncN(rstSyncQ),
    .swWr(wrSrc),
    .swData(regWdata),
    .hwWr(1'b0),
    .hwData(32'h00000000),
    .value(srcAddr)
  );

  // tail reached when the completed descriptor is the pause point
  wire atTail = curPtr == tailPtr;
  // sequential successor of a paused descriptor
  wire [31:0] seqNext = (curPtr + DESC_STRIDE) & PTR_MASK;

  // hardware updates of the current pointer
  // error pointer capture
  always_comb begin
    hwCurWr = 1'b0;
    hwCurData = curPtr;
    if (errValid) begin
      hwCurWr = 1'b1;
      hwCurData = errDescPtr;
    end else if (stateQ == ST_EXEC && descDone && !atTail) begin
      hwCurWr = 1'b1;
      hwCurData = nextDescPtr;
    end else if (stateQ == ST_PAUSE && wrTail) begin
      hwCurWr = 1'b1;
      hwCurData = seqNext;
    end
  end

  // state transitions
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_IDLE: begin
        if (wrTail && chainMode) begin
          stateD = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (errValid) begin
          stateD = ST_IDLE;
        end else if (fetchReady) begin
          stateD = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (errValid) begin
          stateD = ST_IDLE;
        end else if (descDone) begin
          stateD = atTail ? ST_PAUSE : ST_FETCH;
        end
      end
      ST_PAUSE: begin
        if (wrTail) begin
          stateD = ST_FETCH;
        end
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // simple transfer request latch
  logic simpleQ;
  always_ff @(posedge ref_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      simpleQ <= 1'b0;
    end else begin
      simpleQ <= simpleStart && !chainMode && stateQ == ST_IDLE;
    end
  end

  // busy tail write only moves pause point (no state change above)
  assign fetchReq = stateQ == ST_FETCH;
  assign fetchAddr = curPtr;
  assign simpleReq = simpleQ;
  // full source address drives simple reads
  assign simpleSrcAddr = srcAddr;
  assign engineIdle = stateQ == ST_IDLE && !simpleQ;
  assign enginePaused = stateQ == ST_PAUSE;

  // read mux; unmapped offsets read zero
  wire [31:0] rdMux = selCur ? curPtr : selTail ? tailPtr : selSrc ? srcAddr : 32'h00000000;
  // read data register, so the data output leaves from a flip-flop
  logic [31:0] regRdataQ;
  always_ff @(posedge ref_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      regRdataQ <= 32'h00000000;
    end else begin
      regRdataQ <= rdMux;
    end
  end
  // read data stands one cycle after the address
  assign regRdata = regRdataQ;

  // a_ptr_low_zero: pointer alignment
  a_ptr_low_zero: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    curPtr[5:0] == 6'h00 && tailPtr[5:0] == 6'h00) else $error("pointer low bits not zero");
  a_tail_start: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    stateQ == ST_IDLE && wrTail && chainMode && !errValid |=> fetchReq && fetchAddr == $past(curPtr))
    else $error("tail write did not start fetch");
  a_tail_pause: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    stateQ == ST_EXEC && descDone && atTail && !errValid |=> enginePaused)
    else $error("no pause at tail");
  a_resume_next: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    enginePaused && wrTail && !errValid |=> fetchReq && curPtr == $past(seqNext))
    else $error("resume not at next descriptor");
  a_err_capture: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    errValid |=> curPtr == ($past(errDescPtr) & PTR_MASK)) else $error("error pointer lost");
  a_busy_tail: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    (stateQ == ST_FETCH || stateQ == ST_EXEC) && wrTail
    && !fetchReady && !descDone && !errValid
    |=> stateQ == $past(stateQ) && curPtr == $past(curPtr))
    else $error("busy tail write changed state");
  a_src_exact: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    wrSrc |=> simpleSrcAddr == $past(regWdata)) else $error("source address altered");
  a_simple_mode: assert property (@(posedge ref_clk) disable iff (!rstSyncQ)
    !chainMode && stateQ == ST_IDLE |=> stateQ == ST_IDLE) else $error("chain without select");
  c_chain_run: cover property (@(posedge ref_clk) fetchReq ##1 stateQ == ST_EXEC);
  c_pause_hit: cover property (@(posedge ref_clk) enginePaused ##1 fetchReq);
  c_simple_go: cover property (@(posedge ref_clk) simpleReq);
endmodule : sgdp_desc_ptrs

//--- sgdp_exec_model.sv
`timescale 1ns/100ps
// execution side: takes fetches, then completes or faults descriptors
module sgdp_exec_model
  import sgdp_pkg::*;
(
  input wire logic clk,
  input wire logic fetchReq,
  input wire logic [31:0] fetchAddr,
  input wire logic errInject,
  input wire logic [31:0] errAt,
  output logic fetchReady,
  output logic descDone,
  output logic [31:0] nextDescPtr,
  output logic errValid,
  output logic [31:0] errDescPtr
);
  logic run; // a descriptor is in flight
  logic [3:0] cnt; // cycles since the fetch was taken
  logic [31:0] addr; // descriptor being worked on
  initial begin
    {run, cnt, addr, fetchReady, descDone, errValid} = '0;
  end
  // links point at sequential valid descriptors
  assign nextDescPtr = descDone ? addr + DESC_STRIDE : ~(addr + DESC_STRIDE);
  // fault address only means something with its pulse
  assign errDescPtr = errValid ? errAt : ~errAt;
  // fetch done three cycles after it is taken, descriptor done after six
  always @(negedge clk) begin
    fetchReady <= 1'b0;
    descDone <= 1'b0;
    errValid <= 1'b0;
    cnt <= cnt + 4'h1;
    if (!run && fetchReq) begin
      run <= 1'b1;
      cnt <= 4'h0;
      addr <= fetchAddr;
    end else if (run && cnt == 4'h2) begin
      fetchReady <= !errInject;
      errValid <= errInject;
      run <= !errInject;
    end else if (run && cnt == 4'h5) begin
      descDone <= 1'b1;
      run <= 1'b0;
    end
  end
endmodule : sgdp_exec_model

//--- sg_dma_descriptor_pointers_tb_top.sv
`timescale 1ns/100ps
// register-level tests of the descriptor pointer block
module sg_dma_descriptor_pointers_tb_top import sgdp_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWr = 1'b0;
  logic [REG_AW-1:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic scatterGatherSelect = 1'b0;
  logic simpleStart = 1'b0;
  logic errInject = 1'b0;
  logic [31:0] errAt = 32'h0;
  logic fetchReady, descDone, errValid, fetchReq, simpleReq, engineIdle, enginePaused;
  logic [31:0] regRdata, nextDescPtr, errDescPtr, fetchAddr, simpleSrcAddr;
  int errors = 0;
  int samplesChecked = 0;
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  sgdp_desc_ptrs dut_u (.ref_clk, .rst_n, .regWr, .regAddr, .regWdata, .regRdata,
    .scatterGatherSelect, .fetchReady, .descDone, .nextDescPtr, .errValid, .errDescPtr,
    .simpleStart, .fetchReq, .fetchAddr, .simpleReq, .simpleSrcAddr, .engineIdle,
    .enginePaused);
  sgdp_exec_model model_u (.clk(ref_clk), .fetchReq, .fetchAddr, .errInject, .errAt,
    .fetchReady, .descDone, .nextDescPtr, .errValid, .errDescPtr);
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one-cycle write strobe launched at the falling edge
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWr = 1'b0;
  endtask : regWrite
  // read data is registered: address at one falling edge, data at the next
  task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
    @(negedge ref_clk);
    regAddr = a;
    @(negedge ref_clk);
    check(regRdata, exp);
  endtask : regRead
  // bounded wait for pause (1) or idle (0); running out counts as a mismatch
  task automatic waitFor(input logic paused);
    for (int i = 0; i < 60; i++) begin
      if ((paused ? enginePaused : engineIdle) === 1'b1) break;
      @(negedge ref_clk);
    end
    check({31'h0, paused ? enginePaused : engineIdle}, 32'h1);
  endtask : waitFor
  task automatic printVerdict;
    $display("errors=%0d samplesChecked=%0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : printVerdict
  // watchdog far beyond the roughly 80 cycles the tests need
  initial begin
    #100000;
    errors++;
    printVerdict();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    regRead(CUR_DESC_OFS, CUR_DESC_RST);
    regRead(TAIL_DESC_OFS, TAIL_DESC_RST);
    regRead(SRC_ADDR_OFS, SRC_ADDR_RST);
    check({31'h0, engineIdle}, 32'h1);
    regRead(8'h20, 32'h0);
    regWrite(CUR_DESC_OFS, 32'h1000007f);
    regRead(CUR_DESC_OFS, 32'h10000040);
    regWrite(TAIL_DESC_OFS, 32'h100000bf);
    check({31'h0, fetchReq}, 32'h0);
    regRead(TAIL_DESC_OFS, 32'h10000080);
    regWrite(SRC_ADDR_OFS, 32'h000c5677);
    regRead(SRC_ADDR_OFS, 32'h000c5677);
    simpleStart = 1'b1;
    @(negedge ref_clk);
    simpleStart = 1'b0;
    check({31'h0, simpleReq}, 32'h1);
    check(simpleSrcAddr, 32'h000c5677);
    scatterGatherSelect = 1'b1;
    regWrite(CUR_DESC_OFS, 32'h00000100);
    regWrite(TAIL_DESC_OFS, 32'h00000140);
    check({fetchAddr[31:1], fetchReq}, 32'h00000101);
    regWrite(TAIL_DESC_OFS, 32'h00000180);
    check({fetchAddr[31:1], fetchReq}, 32'h00000101);
    waitFor(1'b1);
    regRead(CUR_DESC_OFS, 32'h00000180);
    check({31'h0, fetchReq}, 32'h0);
    regWrite(TAIL_DESC_OFS, 32'h000001c0);
    check({fetchAddr[31:1], fetchReq}, 32'h000001c1);
    waitFor(1'b1);
    // fault on the next fetch reports another descriptor
    errInject = 1'b1;
    errAt = 32'h00000ac0;
    regWrite(TAIL_DESC_OFS, 32'h00000200);
    waitFor(1'b0);
    regRead(CUR_DESC_OFS, 32'h00000ac0);
    check({31'h0, engineIdle}, 32'h1);
    printVerdict();
  end
endmodule : sg_dma_descriptor_pointers_tb_top
